// ==== src/zes_host.sv ====
`timescale 1ns/100ps
// Operation
// - Each zone pass opens by reading locations until one is not all ones, and a zone reading all ones is reported blank and skipped.
// - A zone to be rewritten is first programmed to all zeros location by location with the write procedure.
// - After an erase pulse, locations are verified for all ones from the held address until the last or a failure.
// - In byte-wide mode even and odd addresses are erased and verified in separate passes.
// - A failed verify triggers another erase pulse unless MAX_PULSES pulses have been given, and verification resumes at the held address.
// - After a zone verifies erased the procedure restarts for the next zone or word-wide zone pair.
// - Commands are written only with write strobe and card select both low; write strobe stays high otherwise, card select also drops for reads.
// - Card selects come from the bus cycle and word-wide setting, output enable from the read strobe, only one driver at a time.
// - Erase is the erase code written twice, running from the second strobe until the next strobe.
// - Each location check writes the erase-verify code with its address and then reads it back.
// - Each zero-fill step writes setup and data, then the write-verify code, then compares the read-back.
// - An abort writes the all-ones reset code twice, or once after a read when a read cycle starts in the abort cycle, after which a valid command follows.
module zes_host #(
    parameter int unsigned ERASE_CYC  = zes_pkg::ERASE_CYC,
    parameter int unsigned ZONE_LOCS  = zes_pkg::ZONE_LOCS,
    parameter int unsigned MAX_PULSES = zes_pkg::MAX_ERASE_PULSES,
    parameter int unsigned MAX_TRIES  = zes_pkg::MAX_WRITE_TRIES
) (
    // Clock and reset
    input  wire logic                        clk,
    input  wire logic                        nrst,
    // User command
    input  wire logic                        start,
    input  wire logic                        abort,
    input  wire logic [zes_pkg::ZONE_W-1:0]  zone_first,
    input  wire logic [zes_pkg::ZONE_W-1:0]  zone_count,
    input  wire logic                        word_wide,
    input  wire logic                        fill_en,
    // User status
    output logic                             busy,
    output logic                             done,
    output logic                             failed,
    output logic                             aborted,
    output logic                             blank_seen,
    // Card pins
    output zes_pkg::zes_pins_s               pins,
    input  wire logic [zes_pkg::DATA_W-1:0]  card_data_in
);

    // ------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------
    if (ZONE_LOCS < 2 || ZONE_LOCS > (1 << zes_pkg::LOC_W)) begin : g_chk_locs
        $error("ZONE_LOCS out of range");
    end
    if (ERASE_CYC < 1 || ERASE_CYC >= (1 << zes_pkg::TMR_W)) begin : g_chk_erase
        $error("ERASE_CYC out of range");
    end
    if (MAX_PULSES < 1 || MAX_PULSES >= (1 << zes_pkg::PUL_W)) begin : g_chk_pul
        $error("MAX_PULSES out of range");
    end
    if (MAX_TRIES < 1 || MAX_TRIES >= (1 << zes_pkg::TRY_W)) begin : g_chk_try
        $error("MAX_TRIES out of range");
    end

    typedef enum logic [4:0] {
        S_IDLE, S_PRE_RD,
        S_FILL_SET, S_FILL_DAT, S_FILL_WT, S_FILL_VC, S_FILL_REC, S_FILL_RD,
        S_ER_SET, S_ER_GO, S_ER_WT, S_EV_CMD, S_EV_REC, S_EV_RD,
        S_RD_CMD, S_NEXT, S_AB_1, S_AB_2, S_AB_RD, S_DONE
    } zes_state_e;

    // ------------------------------------------------------------
    // Per-state bus decode
    // ------------------------------------------------------------
    function automatic logic zes_is_rd(input zes_state_e s);
        return (s == S_PRE_RD) || (s == S_FILL_RD) || (s == S_EV_RD);
    endfunction : zes_is_rd

    function automatic logic zes_is_wr(input zes_state_e s);
        return (s == S_FILL_SET) || (s == S_FILL_DAT) || (s == S_FILL_VC) || (s == S_ER_SET) ||
               (s == S_ER_GO) || (s == S_EV_CMD) || (s == S_RD_CMD) || (s == S_AB_1) ||
               (s == S_AB_2) || (s == S_AB_RD);
    endfunction : zes_is_wr

    function automatic logic [7:0] zes_cmd(input zes_state_e s);
        unique case (s)
            S_FILL_SET:       return zes_pkg::CMD_WRITE_SETUP;
            S_FILL_VC:        return zes_pkg::CMD_WRITE_VFY;
            S_ER_SET, S_ER_GO: return zes_pkg::CMD_ERASE;
            S_EV_CMD:         return zes_pkg::CMD_ERASE_VFY;
            S_AB_1, S_AB_2:   return zes_pkg::CMD_RESET;
            default:          return zes_pkg::CMD_READ;
        endcase
    endfunction : zes_cmd

    zes_state_e                    st_q, st_d;
    logic                          bus_act_q, bus_wr_q;
    logic [3:0]                    bus_cnt_q;
    logic                          bus_fin, bus_start;
    logic [zes_pkg::DATA_W-1:0]    din_m_q, din_s_q;
    logic [zes_pkg::TMR_W-1:0]     tmr_q, tmr_val;
    logic                          tmr_ld;
    logic [zes_pkg::LOC_W-1:0]     loc_q;
    logic [zes_pkg::PUL_W-1:0]     pul_q;
    logic [zes_pkg::TRY_W-1:0]     try_q;
    logic [zes_pkg::ZONE_W-1:0]    zone_q, left_q;
    logic                          par_q, word_q, fill_q, abort_q;
    logic                          loc_clr, loc_inc, try_clr, try_inc, pul_clr, pul_inc;
    logic                          par_flip, zone_inc, fail_set, blank_set, abort_go;
    logic                          last_loc, rd_ones, rd_zero;

    assign last_loc = (loc_q == zes_pkg::LOC_W'(ZONE_LOCS - 1));
    assign rd_ones  = word_q ? (din_s_q == {2{zes_pkg::DATA_ERASED}}) : (din_s_q[7:0] == zes_pkg::DATA_ERASED);
    assign rd_zero  = word_q ? (din_s_q == {2{zes_pkg::DATA_FILLED}}) : (din_s_q[7:0] == zes_pkg::DATA_FILLED);
    assign bus_start = (zes_is_rd(st_q) || zes_is_wr(st_q)) && !bus_act_q;
    assign bus_fin   = bus_act_q && (bus_cnt_q == (bus_wr_q ? 4'(zes_pkg::WC_CYC - 1) : 4'(zes_pkg::RD_CYC - 1)));
    assign abort_go  = abort_q && !bus_act_q && (st_q != S_IDLE) && (st_q != S_AB_1) && (st_q != S_AB_2) &&
                       (st_q != S_AB_RD) && (st_q != S_DONE);
    assign busy      = (st_q != S_IDLE);

    // ------------------------------------------------------------
    // Sequence control
    // ------------------------------------------------------------
    always_comb begin
        st_d = st_q;
        {loc_clr, loc_inc, try_clr, try_inc, pul_clr, pul_inc} = 6'h00;
        {par_flip, zone_inc, fail_set, blank_set, tmr_ld} = 5'h00;
        tmr_val = '0;
        unique case (st_q)
            S_IDLE: if (start) begin
                st_d = S_PRE_RD;
                loc_clr = 1'b1;
            end
            S_PRE_RD: if (bus_fin) begin
                if (!rd_ones) begin
                    loc_clr = 1'b1;
                    try_clr = 1'b1;
                    pul_clr = 1'b1;
                    st_d = fill_q ? S_FILL_SET : S_ER_SET;
                end else if (last_loc) begin
                    blank_set = 1'b1;
                    st_d = S_NEXT;
                end else begin
                    loc_inc = 1'b1;
                end
            end
            S_FILL_SET: if (bus_fin) st_d = S_FILL_DAT;
            S_FILL_DAT: if (bus_fin) begin
                st_d = S_FILL_WT;
                tmr_ld = 1'b1;
                tmr_val = zes_pkg::TMR_W'(zes_pkg::WOP_CYC);
            end
            S_FILL_WT: if (tmr_q == '0) st_d = S_FILL_VC;
            S_FILL_VC: if (bus_fin) begin
                st_d = S_FILL_REC;
                tmr_ld = 1'b1;
                tmr_val = zes_pkg::TMR_W'(zes_pkg::REC_CYC);
            end
            S_FILL_REC: if (tmr_q == '0) st_d = S_FILL_RD;
            S_FILL_RD: if (bus_fin) begin
                if (rd_zero) begin
                    try_clr = 1'b1;
                    if (last_loc) begin
                        loc_clr = 1'b1;
                        st_d = S_ER_SET;
                    end else begin
                        loc_inc = 1'b1;
                        st_d = S_FILL_SET;
                    end
                end else if (try_q == zes_pkg::TRY_W'(MAX_TRIES - 1)) begin
                    fail_set = 1'b1;
                    st_d = S_AB_1;
                end else begin
                    try_inc = 1'b1;
                    st_d = S_FILL_SET;
                end
            end
            S_ER_SET: if (bus_fin) st_d = S_ER_GO;
            S_ER_GO: if (bus_fin) begin
                pul_inc = 1'b1;
                st_d = S_ER_WT;
                tmr_ld = 1'b1;
                tmr_val = zes_pkg::TMR_W'(ERASE_CYC);
            end
            S_ER_WT: if (tmr_q == '0) st_d = S_EV_CMD;
            S_EV_CMD: if (bus_fin) begin
                st_d = S_EV_REC;
                tmr_ld = 1'b1;
                tmr_val = zes_pkg::TMR_W'(zes_pkg::REC_CYC);
            end
            S_EV_REC: if (tmr_q == '0) st_d = S_EV_RD;
            S_EV_RD: if (bus_fin) begin
                if (rd_ones) begin
                    if (last_loc) begin
                        st_d = S_RD_CMD;
                    end else begin
                        loc_inc = 1'b1;
                        st_d = S_EV_CMD;
                    end
                end else if (pul_q >= zes_pkg::PUL_W'(MAX_PULSES)) begin
                    fail_set = 1'b1;
                    st_d = S_AB_1;
                end else begin
                    st_d = S_ER_SET;
                end
            end
            S_RD_CMD: if (bus_fin) st_d = S_NEXT;
            S_NEXT: begin
                loc_clr = 1'b1;
                if (!word_q && !par_q) begin
                    par_flip = 1'b1;
                    st_d = S_PRE_RD;
                end else if (left_q <= zes_pkg::ZONE_W'(1)) begin
                    st_d = S_DONE;
                end else begin
                    zone_inc = 1'b1;
                    st_d = S_PRE_RD;
                end
            end
            S_AB_1: if (bus_fin) st_d = S_AB_2;
            S_AB_2: if (bus_fin) st_d = S_AB_RD;
            S_AB_RD: if (bus_fin) st_d = S_DONE;
            S_DONE: st_d = S_IDLE;
        endcase
        if (abort_go) begin
            st_d = S_AB_1;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) st_q <= S_IDLE;
        else       st_q <= st_d;
    end

    // ------------------------------------------------------------
    // Job context
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            {zone_q, left_q} <= '0;
            {par_q, word_q, fill_q} <= 3'h0;
        end else if (st_q == S_IDLE && start) begin
            zone_q <= zone_first;
            left_q <= zone_count;
            par_q  <= 1'b0;
            word_q <= word_wide;
            fill_q <= fill_en;
        end else if (par_flip) begin
            par_q <= 1'b1;
        end else if (zone_inc) begin
            zone_q <= zone_q + zes_pkg::ZONE_W'(1);
            left_q <= left_q - zes_pkg::ZONE_W'(1);
            par_q  <= 1'b0;
        end
    end

    // Held address doubles as the resume point after a failed verify
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst)        loc_q <= '0;
        else if (loc_clr) loc_q <= '0;
        else if (loc_inc) loc_q <= loc_q + zes_pkg::LOC_W'(1);
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pul_q <= '0;
            try_q <= '0;
        end else begin
            if (pul_clr)      pul_q <= '0;
            else if (pul_inc) pul_q <= pul_q + zes_pkg::PUL_W'(1);
            if (try_clr)      try_q <= '0;
            else if (try_inc) try_q <= try_q + zes_pkg::TRY_W'(1);
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst)       tmr_q <= '0;
        else if (tmr_ld) tmr_q <= tmr_val;
        else if (tmr_q != '0) tmr_q <= tmr_q - zes_pkg::TMR_W'(1);
    end

    // Abort request is held until the bus is quiet; a new request wins over the clear
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst)          abort_q <= 1'b0;
        else if (abort && st_q != S_IDLE) abort_q <= 1'b1;
        else if (abort_go || st_q == S_IDLE) abort_q <= 1'b0;
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            {done, failed, aborted, blank_seen} <= 4'h0;
        end else begin
            done <= (st_q == S_DONE);
            if (st_q == S_IDLE && start) begin
                {failed, aborted, blank_seen} <= 3'h0;
            end else begin
                failed     <= failed | fail_set;
                aborted    <= aborted | abort_go;
                blank_seen <= blank_seen | blank_set;
            end
        end
    end

    // ------------------------------------------------------------
    // Card bus cycles
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            bus_act_q <= 1'b0;
            bus_wr_q  <= 1'b0;
            bus_cnt_q <= '0;
        end else if (bus_start) begin
            bus_act_q <= 1'b1;
            bus_wr_q  <= zes_is_wr(st_q);
            bus_cnt_q <= '0;
        end else if (bus_fin) begin
            bus_act_q <= 1'b0;
        end else if (bus_act_q) begin
            bus_cnt_q <= bus_cnt_q + 4'(1);
        end
    end

    // Read data comes from the card pins, outside this clock
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            din_m_q <= '0;
            din_s_q <= '0;
        end else begin
            din_m_q <= card_data_in;
            din_s_q <= din_m_q;
        end
    end

    // Reset leaves all strobes high so the card stays in read state
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pins.addr          <= '0;
            pins.data          <= '0;
            pins.data_oe       <= 1'b0;
            pins.card_select_n <= zes_pkg::SEL_NONE;
            pins.oe_n          <= 1'b1;
            pins.we_n          <= 1'b1;
        end else begin
            pins.addr          <= {zone_q, loc_q, par_q & ~word_q};
            pins.data          <= {2{zes_cmd(st_q)}};
            pins.data_oe       <= bus_act_q && bus_wr_q;
            pins.card_select_n <= !bus_act_q ? zes_pkg::SEL_NONE :
                                  (word_q ? zes_pkg::SEL_WORD : zes_pkg::SEL_BYTE);
            pins.oe_n          <= !(bus_act_q && !bus_wr_q);
            pins.we_n          <= !(bus_act_q && bus_wr_q && bus_cnt_q >= 4'(zes_pkg::CS_CYC) &&
                                    bus_cnt_q < 4'(zes_pkg::CS_CYC + zes_pkg::WP_CYC));
        end
    end

endmodule : zes_host

// ==== src/zes_pkg.sv ====
package zes_pkg;

    // ------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------
    localparam int ZONE_W = 4;
    localparam int LOC_W  = 18;
    localparam int ADDR_W = ZONE_W + LOC_W + 1;
    localparam int DATA_W = 16;
    localparam int TMR_W  = 24;
    localparam int PUL_W  = 16;
    localparam int TRY_W  = 5;

    // ------------------------------------------------------------
    // Command codes, one byte lane; both lanes carry it
    // ------------------------------------------------------------
    localparam logic [7:0] CMD_READ        = 8'h00;
    localparam logic [7:0] CMD_ERASE       = 8'h20;
    localparam logic [7:0] CMD_ERASE_VFY   = 8'ha0;
    localparam logic [7:0] CMD_WRITE_SETUP = 8'h40;
    localparam logic [7:0] CMD_WRITE_VFY   = 8'hc0;
    localparam logic [7:0] CMD_RESET       = 8'hff;
    localparam logic [7:0] DATA_ERASED     = 8'hff;
    localparam logic [7:0] DATA_FILLED     = 8'h00;

    // ------------------------------------------------------------
    // Chip select patterns and reset values
    // ------------------------------------------------------------
    localparam logic [1:0] SEL_NONE = 2'h3;
    localparam logic [1:0] SEL_BYTE = 2'h2;
    localparam logic [1:0] SEL_WORD = 2'h0;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int  CLK_MHZ    = 20;
    localparam int  T_CS_NS    = 40;
    localparam int  T_WP_NS    = 100;
    localparam int  T_WC_NS    = 200;
    localparam int  T_ACC_NS   = 200;
    localparam int  T_WHGL_US  = 6;
    localparam int  T_WRITE_US = 10;
    localparam real T_ERASE_MS = 9.5;

    localparam int CS_CYC    = (T_CS_NS * CLK_MHZ + 999) / 1000;
    localparam int WP_CYC    = (T_WP_NS * CLK_MHZ + 999) / 1000;
    localparam int WC_CYC    = (T_WC_NS * CLK_MHZ + 999) / 1000;
    localparam int ACC_CYC   = (T_ACC_NS * CLK_MHZ + 999) / 1000;
    localparam int REC_CYC   = T_WHGL_US * CLK_MHZ;
    localparam int WOP_CYC   = T_WRITE_US * CLK_MHZ;
    localparam int ERASE_CYC = int'($ceil(T_ERASE_MS * 1000.0 * CLK_MHZ));
    // Output pins lag one cycle, read data passes two sync stages
    localparam int RD_CYC    = ACC_CYC + 4;

    localparam int ZONE_LOCS        = 262144;
    localparam int MAX_WRITE_TRIES  = 25;
    localparam int MAX_ERASE_PULSES = 3000;

    // ------------------------------------------------------------
    // Card pin bundle
    // ------------------------------------------------------------
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
        logic              data_oe;
        logic [1:0]        card_select_n;
        logic              oe_n;
        logic              we_n;
    } zes_pins_s;

endpackage : zes_pkg

// ==== tb/zes_assertions.sv ====
`timescale 1ns/100ps
module zes_checker #(
    parameter int unsigned ERASE_CYC = zes_pkg::ERASE_CYC
) (
    // Clock and reset
    input wire logic               clk,
    input wire logic               nrst,
    // Status and card pins
    input wire logic               busy,
    input wire logic               done,
    input wire logic               failed,
    input wire logic               aborted,
    input wire logic               blank_seen,
    input wire zes_pkg::zes_pins_s pins
);
    logic        we_q;
    logic [7:0]  cmd_q;
    logic [7:0]  cmd2_q;
    int unsigned gap_q;
    logic [1:0]  cs;
    logic        we;
    logic        oe;
    assign cs = pins.card_select_n;
    assign we = pins.we_n;
    assign oe = pins.oe_n;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);
    // Gaps run from the strobe rise, where the card starts its work
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            we_q   <= 1'b1;
            cmd_q  <= 8'h00;
            cmd2_q <= 8'h00;
            gap_q  <= 32'hffff;
        end else begin
            we_q <= we;
            if (we && !we_q) begin
                cmd_q  <= pins.data[7:0];
                cmd2_q <= cmd_q;
                gap_q  <= 0;
            end else if (gap_q < 32'hffff) begin
                gap_q <= gap_q + 1;
            end
        end
    end
    wr_select_a: assert property (!we |-> cs != zes_pkg::SEL_NONE)
        else $error("write strobe without select");
    wr_width_a: assert property ($fell(we) |=> !we ##1 we)
        else $error("write strobe width wrong");
    no_contend_a: assert property (!oe |-> we && !pins.data_oe)
        else $error("read strobe while host drives");
    rd_width_a: assert property ($fell(oe) |-> cs != zes_pkg::SEL_NONE ##1 (!oe)[*7] ##1 oe)
        else $error("read strobe shape wrong");
    byte_sel_a: assert property (cs != 2'h1)
        else $error("odd select without even");
    wr_hold_a: assert property ($rose(we) |-> pins.data_oe && $stable(pins.data) && $stable(pins.addr))
        else $error("write data not held");
    erase_time_a: assert property ($fell(we) && cmd2_q == 8'h20 && cmd_q == 8'h20 |-> gap_q >= ERASE_CYC)
        else $error("erase cut short");
    fill_time_a: assert property ($fell(we) && cmd2_q == 8'h40 && cmd_q == 8'h00 |-> gap_q >= zes_pkg::WOP_CYC)
        else $error("write cut short");
    vfy_wait_a: assert property ($fell(oe) && (cmd_q == 8'ha0 || cmd_q == 8'hc0) |-> gap_q >= zes_pkg::REC_CYC)
        else $error("verify read too early");
    idle_bus_a: assert property (!busy && !$past(busy) |-> cs == zes_pkg::SEL_NONE && we && oe)
        else $error("bus active while idle");
    cover property (done && blank_seen);
    cover property (done && failed);
    cover property (done && aborted);
    cover property ($fell(we) && cmd2_q == 8'h20 && cmd_q == 8'h20);
endmodule : zes_checker

bind zes_host zes_checker #(.ERASE_CYC(ERASE_CYC)) u_zes_checker (
    .clk(clk), .nrst(nrst), .busy(busy), .done(done), .failed(failed),
    .aborted(aborted), .blank_seen(blank_seen), .pins(pins));

// ==== tb/zes_card.sv ====
`timescale 1ns/100ps
module zes_card #(
    parameter int LOCS   = 4,
    parameter int PULSES = 2,
    parameter int LAG    = 150
) (
    // Host side
    input  wire zes_pkg::zes_pins_s pins,
    input  wire logic               prog_high,
    // Read data
    output logic [15:0]             dout
);
    logic [15:0] mem [int];
    int          pulses [int];
    logic [15:0] bg, last, wd, val;
    logic [7:0]  c, prevc;
    int          st, a, lat, ek, wa, total, fills, verifies, resets;
    logic        sel;
    assign sel = pins.card_select_n != zes_pkg::SEL_NONE;
    assign #(LAG) dout = val;
    function automatic logic [15:0] rd(int ad);
        return mem.exists(ad) ? mem[ad] : bg;
    endfunction : rd
    task automatic preset(logic [15:0] v);
        mem.delete();
        pulses.delete();
        bg = v;
        st = 0;
        total = 0;
        fills = 0;
        verifies = 0;
        resets = 0;
    endtask : preset
    initial preset(16'hffff);
    // Each pulse clears a further slice, so verify must resume mid-zone
    always @(posedge pins.we_n) if (sel) begin
        c = pins.data[7:0];
        a = int'(pins.addr);
        if (prog_high && st == 2) begin
            pulses[ek] = pulses.exists(ek) ? pulses[ek] + 1 : 1;
            total++;
            for (int l = 0; l < LOCS; l++) begin
                if (pulses[ek] * LOCS >= (l + 1) * PULSES) mem[(ek / 2) * 2**19 + 2 * l + ek % 2] = 16'hffff;
            end
        end
        if (prog_high && st == 5) begin
            mem[wa] = rd(wa) & wd;
            fills++;
        end
        case (st)
            1: st = c == 8'h20 ? 2 : c == 8'hff ? 7 : 0;
            4: begin
                st = c == 8'hff ? 7 : 5;
                wd = pins.data;
                wa = a;
            end
            7: st = 0;
            default: begin
                st = c == 8'h20 ? 1 : c == 8'h40 ? 4 : c == 8'ha0 ? 3 : c == 8'hc0 ? 6 : 0;
                lat = a;
            end
        endcase
        if (st == 2) ek = (a / 2**19) * 2 + a % 2;
        if (c == 8'ha0 && st == 3) verifies++;
        if (c == 8'hff && prevc == 8'hff) resets++;
        prevc = c;
    end
    // A released bus shows the inverse of the last word, never a stale match
    always @* begin
        if (sel && !pins.oe_n) begin
            last = rd(st == 3 || st == 6 ? lat : int'(pins.addr));
            val = last;
        end else begin
            val = ~last;
        end
    end
endmodule : zes_card

// ==== tb/zone_erase_sequencer_bench.sv ====
`timescale 1ns/100ps
module zone_erase_sequencer_bench;
    localparam int LOCS = 4;
    localparam int Z    = 2**19;
    logic               clk = 1'b0;
    logic               nrst = 1'b0;
    logic               start = 1'b0;
    logic               abort = 1'b0;
    logic [3:0]         zone_first = 4'h0;
    logic [3:0]         zone_count = 4'h1;
    logic               word_wide = 1'b0;
    logic               fill_en = 1'b0;
    logic               prog_high = 1'b1;
    logic               busy, done, failed, aborted, blank_seen;
    logic [15:0]        card_data;
    zes_pkg::zes_pins_s pins;
    int                 num_errors = 0;
    int                 checks = 0;
    always #25 clk = ~clk;
    zes_host #(.ERASE_CYC(20), .ZONE_LOCS(LOCS), .MAX_PULSES(3)) u_zes_host (
        .clk(clk), .nrst(nrst), .start(start), .abort(abort), .zone_first(zone_first),
        .zone_count(zone_count), .word_wide(word_wide), .fill_en(fill_en), .busy(busy),
        .done(done), .failed(failed), .aborted(aborted), .blank_seen(blank_seen),
        .pins(pins), .card_data_in(card_data));
    zes_card u_zes_card (
        .pins(pins), .prog_high(prog_high), .dout(card_data));
    task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic end_of_test;
        $display("checks %0d errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : end_of_test
    // One job; abort pulses after ab cycles when ab is nonzero
    task automatic run(logic [3:0] zf, logic [3:0] zc, logic ww, logic fe, int ab);
        int n;
        @(negedge clk);
        zone_first = zf;
        zone_count = zc;
        word_wide = ww;
        fill_en = fe;
        start = 1'b1;
        @(negedge clk);
        start = 1'b0;
        check("busy", busy, 1'b1);
        for (n = 1; n < 40000 && done !== 1'b1; n++) begin
            abort = n == ab;
            @(negedge clk);
        end
        abort = 1'b0;
        check("done", done, 1'b1);
        check("idle", busy, 1'b0);
    endtask : run
    task automatic t_blank;
        u_zes_card.preset(16'hffff);
        run(4'h1, 4'h1, 1'b0, 1'b1, 0);
        check("blank_seen", blank_seen, 1'b1);
        check("erase pulses", u_zes_card.total, 0);
        check("fills", u_zes_card.fills, 0);
    endtask : t_blank
    task automatic t_word;
        u_zes_card.preset(16'h1234);
        run(4'h2, 4'h1, 1'b1, 1'b1, 0);
        check("failed", failed, 1'b0);
        check("fills", u_zes_card.fills, LOCS);
        check("pulses", u_zes_card.pulses[4], 2);
        check("verifies", u_zes_card.verifies, 5);
        for (int l = 0; l < LOCS; l++) check("word", u_zes_card.rd(2 * Z + 2 * l), 16'hffff);
        check("card state", u_zes_card.st, 0);
    endtask : t_word
    task automatic t_byte;
        u_zes_card.preset(16'h00f0);
        run(4'h4, 4'h2, 1'b0, 1'b1, 0);
        check("failed", failed, 1'b0);
        check("byte fills", u_zes_card.fills, 4 * LOCS);
        for (int k = 8; k < 12; k++) begin
            check("pass pulses", u_zes_card.pulses[k], 2);
            check("last byte", u_zes_card.rd((k / 2) * Z + 2 * (LOCS - 1) + k % 2), 16'hffff);
        end
    endtask : t_byte
    task automatic t_vpp;
        u_zes_card.preset(16'h0000);
        prog_high = 1'b0;
        run(4'h3, 4'h1, 1'b1, 1'b0, 0);
        prog_high = 1'b1;
        check("failed", failed, 1'b1);
        check("verifies", u_zes_card.verifies, 3);
        check("resets", u_zes_card.resets, 1);
        check("kept", u_zes_card.rd(3 * Z), 16'h0000);
        check("card state", u_zes_card.st, 0);
    endtask : t_vpp
    task automatic t_abort;
        u_zes_card.preset(16'h1234);
        run(4'h5, 4'h1, 1'b1, 1'b1, 300);
        check("aborted", aborted, 1'b1);
        check("failed", failed, 1'b0);
        check("resets", u_zes_card.resets, 1);
        check("untouched", u_zes_card.rd(5 * Z + 2), 16'h1234);
        check("card state", u_zes_card.st, 0);
    endtask : t_abort
    initial begin
        repeat (20) @(negedge clk);
        nrst = 1'b1;
        t_blank();
        t_word();
        t_byte();
        t_vpp();
        t_abort();
        end_of_test();
    end
    // Whole run is about twelve thousand cycles; this is far beyond it
    initial begin
        #4000000;
        num_errors++;
        end_of_test();
    end
endmodule : zone_erase_sequencer_bench
